// [core/return_set_skip_instr_group.sv]
/*
 * Execute core for returns, bit/flag sets and compare-and-skip of a
 * 4-bit CPU, with an AXI4-Lite register port for issue and state.
 * Assumes software issues one instruction at a time through EXEC.
 */
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.svh"

// What this block does
// (RL1) return pops PC, SP drops, two cycles
// (RL2) interrupt return pops PC in one cycle
// (RL3) interrupt return restores pointers, flags, A, B
// (RL4) return-and-skip pops PC, skips next instruction
// (RL5) flag clear zeroes high-ref flag, carry kept
// (RL6) bit set raises bit j of memory
// (RL7) carry set forces carry, nothing else
// (RL8) port set raises port D bit Y
// (RL9) software keeps Y within 0..3 here
// (RL10) compare skips next when A equals n
// (RL11) compare mismatch lets next instruction run
// (RL12) opcode decoded from word, immediates low bits
module return_set_skip_instr_group (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [`ADDR_W-1:0] awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [`DATA_W-1:0] wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [`ADDR_W-1:0] araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [`DATA_W-1:0]      rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    output logic [3:0]              portD,
    output logic                    highRefEnableFlag
);
    import rss_pkg::*;

    reg_bus_if bus ();

    state_type      state;
    ctx_type        cur;
    ctx_type        saved;
    op_type         op;
    logic [1:0]     bitSel;
    logic           twoCycle;
    logic [`PC_W-1:0] pc;
    logic [`SP_W-1:0] sp;
    logic [`PC_W-1:0] returnStack [`STACK_DEPTH];
    logic [3:0]     mem [`MEM_DEPTH];
    logic [9:0]     word1;
    logic [9:0]     word2;

    function automatic logic isMapped(input logic [`ADDR_W-1:0] a);
        return a == `REG_EXEC || a == `REG_CTRL || a == `REG_STATUS ||
               a == `REG_CORE || a == `REG_MEM;
    endfunction

    axil_slave u_slave (
        .clk     (clk),
        .rst     (rst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .bus     (bus)
    );

    op_decode u_decode (
        .word1    (word1),
        .op       (op),
        .bitSel   (bitSel),
        .twoCycle (twoCycle)
    );

    // register decode; state writes are refused while an op runs
    logic busIdle;
    logic wrExec;
    logic wrCtrl;
    logic wrStatus;
    logic wrCore;
    logic wrMem;
    logic pushReq;
    assign busIdle  = state == ST_IDLE;
    assign wrExec   = bus.wrEn && bus.wrAddr == `REG_EXEC && busIdle;
    assign wrCtrl   = bus.wrEn && bus.wrAddr == `REG_CTRL && busIdle;
    assign wrStatus = bus.wrEn && bus.wrAddr == `REG_STATUS && busIdle;
    assign wrCore   = bus.wrEn && bus.wrAddr == `REG_CORE && busIdle;
    assign wrMem    = bus.wrEn && bus.wrAddr == `REG_MEM && busIdle;
    assign pushReq  = wrCtrl && (bus.wrData[`CTRL_CALL] ||
                                 bus.wrData[`CTRL_INT]);
    assign bus.wrHit = isMapped(bus.wrAddr);
    assign bus.rdHit = isMapped(bus.rdAddr);

    // execute-phase terms
    logic             exec1;
    logic             exec2;
    logic             skipNow;
    logic             run1;
    logic             isReturn;
    logic             accEq;
    logic [3:0]       memIdx;
    logic [1:0]       portSel;
    logic [`SP_W-1:0] spPush;
    logic [`SP_W-1:0] spPop;
    logic [`PC_W-1:0] topPc;
    logic [`PC_W-1:0] pcStep;
    assign exec1    = state == ST_EXEC1;
    assign exec2    = state == ST_EXEC2;
    assign skipNow  = exec1 && cur.skip;
    assign run1     = exec1 && !cur.skip;
    assign isReturn = op == OP_SUB_RETURN || op == OP_INT_RETURN ||
                      op == OP_RETURN_SKIP;
    assign accEq    = cur.acc == word2[3:0]; // RL12
    assign memIdx   = cur.ptrY;
    assign portSel  = cur.ptrY[1:0]; // RL9
    assign spPush   = sp + `SP_W'(1);
    assign spPop    = sp - `SP_W'(1);
    assign topPc    = returnStack[sp];
    assign pcStep   = pc + ((op == OP_COMPARE_IMM_SKIP) ?
                            `PC_W'(2) : `PC_W'(1));

    // read selection
    logic [`DATA_W-1:0] statusWord;
    logic [`DATA_W-1:0] coreWord;
    assign statusWord = {8'h00, portD, 2'h0, highRefEnableFlag,
                         !busIdle, 1'h0, sp, pc};
    assign coreWord   = {9'h000, cur.skip, cur.nopMode, cur.carryFlag,
                         2'h0, cur.ptrZ, cur.ptrY, cur.ptrX,
                         cur.regB, cur.acc};
    assign bus.rdData =
        (bus.rdAddr == `REG_EXEC)   ? {6'h00, word2, 6'h00, word1} :
        (bus.rdAddr == `REG_STATUS) ? statusWord :
        (bus.rdAddr == `REG_CORE)   ? coreWord :
        (bus.rdAddr == `REG_MEM)    ? {28'h0000000, mem[memIdx]} :
        32'h00000000;

    // sequencer: two-cycle ops that are not skipped spend one more cycle in EXEC2
    always_ff @(posedge clk) begin
        if (rst) state <= ST_IDLE;
        else begin
            case (state)
                ST_IDLE:  if (wrExec) state <= ST_EXEC1;
                ST_EXEC1: state <= (run1 && twoCycle) ? ST_EXEC2 : ST_IDLE;
                ST_EXEC2: state <= ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // instruction words, second word only used by the compare
    always_ff @(posedge clk) begin
        if (rst) begin
            word1 <= 10'h000;
            word2 <= 10'h000;
        end else if (wrExec) begin
            word1 <= bus.wrData[`EXEC_W1_LSB +: 10];
            word2 <= bus.wrData[`EXEC_W2_LSB +: 10];
        end
    end

    // program counter: returns reload it from the stack top
    always_ff @(posedge clk) begin
        if (rst) pc <= `PC_RST;
        else if (wrCtrl) pc <= bus.wrData[`CTRL_PC_LSB +: `PC_W];
        else if (skipNow) pc <= pcStep;
        else if (run1) pc <= isReturn ? topPc : pcStep; // RL1 RL2 RL4
    end

    // stack pointer: plain and skip returns drop it in the second cycle
    always_ff @(posedge clk) begin
        if (rst) sp <= `SP_RST;
        else if (pushReq) sp <= spPush;
        else if (exec2 && (op == OP_SUB_RETURN ||
                           op == OP_RETURN_SKIP)) sp <= spPop; // RL1 RL4
        else if (run1 && op == OP_INT_RETURN) sp <= spPop; // RL2
    end

    // stack entries; overflow wraps silently, as in the small core
    for (genvar i = 0; i < `STACK_DEPTH; i++) begin : g_stack
        always_ff @(posedge clk) begin
            if (rst) returnStack[i] <= `PC_RST;
            else if (pushReq && spPush == `SP_W'(i)) returnStack[i] <= pc;
        end
    end

    // data memory nibbles, indexed by the Y pointer
    for (genvar i = 0; i < `MEM_DEPTH; i++) begin : g_mem
        always_ff @(posedge clk) begin
            if (rst) mem[i] <= 4'h0;
            else if (run1 && op == OP_SET_MEM_BIT && memIdx == 4'(i))
                mem[i][bitSel] <= 1'h1; // RL6
            else if (wrMem && memIdx == 4'(i))
                mem[i] <= bus.wrData[3:0];
        end
    end

    // live context; the skip flag is cleared only in a skipped EXEC1 and is loaded in EXEC2,
    // by an idle CORE write or by the interrupt return, so no two of these meet
    always_ff @(posedge clk) begin
        if (rst) cur <= '0;
        else if (run1 && op == OP_INT_RETURN) cur <= saved; // RL3
        else begin
            if (wrCore) begin
                cur.acc       <= bus.wrData[`CORE_A_LSB +: 4];
                cur.regB      <= bus.wrData[`CORE_B_LSB +: 4];
                cur.ptrX      <= bus.wrData[`CORE_X_LSB +: 4];
                cur.ptrY      <= bus.wrData[`CORE_Y_LSB +: 4];
                cur.ptrZ      <= bus.wrData[`CORE_Z_LSB +: 2];
                cur.carryFlag <= bus.wrData[`CORE_CARRY];
                cur.nopMode   <= bus.wrData[`CORE_NOP];
                cur.skip      <= bus.wrData[`CORE_SKIP];
            end
            if (run1 && op == OP_SET_CARRY) cur.carryFlag <= 1'h1; // RL7
            if (skipNow) cur.skip <= 1'h0;
            if (exec2 && op == OP_RETURN_SKIP) cur.skip <= 1'h1; // RL4
            if (exec2 && op == OP_COMPARE_IMM_SKIP)
                cur.skip <= accEq; // RL10 RL11
        end
    end

    // context snapshot taken at interrupt entry
    always_ff @(posedge clk) begin
        if (rst) saved <= '0;
        else if (wrCtrl && bus.wrData[`CTRL_INT]) saved <= cur; // RL3
    end

    // table-reference flag and port D latch
    always_ff @(posedge clk) begin
        if (rst) begin
            highRefEnableFlag <= `HIREF_RST;
            portD             <= `PORT_RST;
        end else if (run1 && op == OP_CLEAR_HIGH_REF) begin
            highRefEnableFlag <= 1'h0; // RL5
        end else if (run1 && op == OP_SET_PORT_D_BIT) begin
            portD[portSel] <= 1'h1; // RL8
        end else if (wrStatus) begin
            highRefEnableFlag <= bus.wrData[`STAT_HIREF];
            portD             <= bus.wrData[`STAT_PORT_LSB +: 4];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ret_pc_load: assert property ((run1 && op == OP_SUB_RETURN) |=>
        pc == $past(topPc) && exec2 && sp == $past(sp)) // RL1
        else $error("return did not reload pc before sp drop");
    a_ret_sp_drop: assert property ((run1 && op == OP_SUB_RETURN) |=>
        ##1 (busIdle && sp == $past(sp, 2) - 3'h1)) // RL1
        else $error("return did not drop sp in second cycle");
    a_reti_single: assert property ((run1 && op == OP_INT_RETURN) |=>
        busIdle && pc == $past(topPc) && sp == $past(spPop)) // RL2
        else $error("interrupt return not done in one cycle");
    a_reti_restore: assert property ((run1 && op == OP_INT_RETURN) |=>
        cur == $past(saved)) // RL3
        else $error("interrupt return did not restore context");
    a_ret_skip_arm: assert property ((run1 && op == OP_RETURN_SKIP) |=>
        (!cur.skip && exec2) ##1 (cur.skip && busIdle)) // RL4
        else $error("return-and-skip did not arm skip");
    a_skip_discard: assert property ((exec1 && cur.skip) |=>
        !cur.skip && busIdle && $stable(portD)) // RL4
        else $error("skipped instruction was not discarded");
    a_href_clear: assert property ((run1 && op == OP_CLEAR_HIGH_REF) |=>
        !highRefEnableFlag && $stable(cur.carryFlag)) // RL5
        else $error("flag clear wrong or carry disturbed");
    a_setbit_mem: assert property ((run1 && op == OP_SET_MEM_BIT) |=>
        mem[$past(memIdx)][$past(bitSel)]) // RL6
        else $error("memory bit not set");
    a_carry_set: assert property ((run1 && op == OP_SET_CARRY) |=>
    // pc still steps past the one-word instruction; sp must not move
        cur.carryFlag && $stable(cur.acc) && $stable(sp) &&
        pc == $past(pc) + 12'h001) // RL7
        else $error("carry set wrong or other state touched");
    a_port_set: assert property ((run1 && op == OP_SET_PORT_D_BIT) |=>
        portD[$past(portSel)] && busIdle) // RL8
        else $error("port D bit not set");
    a_cmp_equal: assert property
        ((run1 && op == OP_COMPARE_IMM_SKIP && accEq) |=>
        ##1 (cur.skip && pc == $past(pc, 2) + 12'h002)) // RL10
        else $error("equal compare did not arm skip");
    a_cmp_differ: assert property
        ((run1 && op == OP_COMPARE_IMM_SKIP && !accEq) |=>
        !cur.skip [*2]) // RL11
        else $error("unequal compare armed skip");
    a_decode_bit: assert property
        ((exec1 && word1[9:2] == `OPC_SETBIT_HI) |->
        op == OP_SET_MEM_BIT && bitSel == word1[1:0]) // RL12
        else $error("bit set not decoded");

    c_reti: cover property (run1 && op == OP_INT_RETURN);
    c_cmp_skip: cover property (exec2 && op == OP_COMPARE_IMM_SKIP
                                && accEq);
    c_ret_then_skip: cover property ((exec2 && op == OP_RETURN_SKIP)
                                     ##[1:20] skipNow);
endmodule // return_set_skip_instr_group

`default_nettype wire

// [core/rss_defs.svh]
/*
 * Shared constants of the return/set/skip execute block: register
 * offsets, field positions, opcodes, reset values and bus answers.
 * Assumes inclusion by bare name from the interface and modules.
 */
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

`define ADDR_W        8
`define DATA_W        32
`define PC_W          12
`define SP_W          3
`define STACK_DEPTH   8
`define MEM_DEPTH     16

// register byte offsets
`define REG_EXEC      8'h00
`define REG_CTRL      8'h04
`define REG_STATUS    8'h08
`define REG_CORE      8'h0C
`define REG_MEM       8'h10

// field positions
`define EXEC_W1_LSB   0
`define EXEC_W2_LSB   16
`define CTRL_CALL     0
`define CTRL_INT      1
`define CTRL_PC_LSB   16
`define STAT_HIREF    17
`define STAT_PORT_LSB 20
`define CORE_A_LSB    0
`define CORE_B_LSB    4
`define CORE_X_LSB    8
`define CORE_Y_LSB    12
`define CORE_Z_LSB    16
`define CORE_CARRY    20
`define CORE_NOP      21
`define CORE_SKIP     22

// opcodes (10-bit instruction words; the bit set gives only its top 8 bits)
`define OPC_SUB_RET   10'h044
`define OPC_RET_SKIP  10'h045
`define OPC_INT_RET   10'h046
`define OPC_CLR_HREF  10'h058
`define OPC_SETBIT_HI 8'h17
`define OPC_SET_CARRY 10'h007
`define OPC_SET_PORT  10'h015
`define OPC_CMP_IMM   10'h025

// reset values and bus answers
`define PC_RST        12'h000
`define SP_RST        3'h7
`define HIREF_RST     1'h0
`define PORT_RST      4'h0
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define STRB_FULL     4'hF

`endif

// [core/rss_pkg.sv]
/*
 * Types of the return/set/skip execute block: decoded operations,
 * sequencer states and the CPU context saved around an interrupt.
 * Assumes nothing beyond the constants header.
 */
package rss_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_SUB_RETURN, OP_INT_RETURN, OP_RETURN_SKIP,
        OP_CLEAR_HIGH_REF, OP_SET_MEM_BIT, OP_SET_CARRY,
        OP_SET_PORT_D_BIT, OP_COMPARE_IMM_SKIP
    } op_type;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC1, ST_EXEC2} state_type;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] regB;
        logic [3:0] ptrX;
        logic [3:0] ptrY;
        logic [1:0] ptrZ;
        logic       carryFlag;
        logic       nopMode;
        logic       skip;
    } ctx_type;
endpackage

// [core/reg_bus_if.sv]
/*
 * Internal register access carrier between the AXI4-Lite slave and
 * the execute core. Assumes one clock; all signals are combinational.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.svh"

interface reg_bus_if;
    logic                wrEn;
    logic [`ADDR_W-1:0]  wrAddr;
    logic [`DATA_W-1:0]  wrData;
    logic                wrHit;
    logic [`ADDR_W-1:0]  rdAddr;
    logic [`DATA_W-1:0]  rdData;
    logic                rdHit;

    modport slave (output wrEn, wrAddr, wrData, rdAddr,
                   input  wrHit, rdHit, rdData);
    modport core  (input  wrEn, wrAddr, wrData, rdAddr,
                   output wrHit, rdHit, rdData);
endinterface // reg_bus_if

`default_nettype wire

// [core/axil_slave.sv]
/*
 * AXI4-Lite slave: holds address and data, issues one write pulse,
 * answers reads one cycle after the address is taken.
 * Assumes the core decodes addresses combinationally.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.svh"

module axil_slave (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [`ADDR_W-1:0] awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [`DATA_W-1:0] wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [`ADDR_W-1:0] araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [`DATA_W-1:0]      rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    reg_bus_if.slave                bus
);
    logic               awHeld;
    logic               wHeld;
    logic               arPending;
    logic [`ADDR_W-1:0] awAddrQ;
    logic [`DATA_W-1:0] wDataQ;
    logic [3:0]         wStrbQ;
    logic [`ADDR_W-1:0] arAddrQ;
    logic               doWrite;
    logic               strbOk;

    // partial writes are refused with an error rather than merged
    assign doWrite    = awHeld && wHeld && !bvalid;
    assign strbOk     = wStrbQ == `STRB_FULL;
    assign bus.wrEn   = doWrite && strbOk;
    assign bus.wrAddr = awAddrQ;
    assign bus.wrData = wDataQ;
    assign bus.rdAddr = arAddrQ;

    // write address and data channels, taken in either order
    always_ff @(posedge clk) begin
        if (rst) begin
            awready <= 1'h0;
            wready  <= 1'h0;
            awHeld  <= 1'h0;
            wHeld   <= 1'h0;
        end else begin
            if (awvalid && awready) begin
                awAddrQ <= awaddr;
                awHeld  <= 1'h1;
                awready <= 1'h0;
            end else if (doWrite) awHeld <= 1'h0;
            else if (!awHeld) awready <= 1'h1;
            if (wvalid && wready) begin
                wDataQ <= wdata;
                wStrbQ <= wstrb;
                wHeld  <= 1'h1;
                wready <= 1'h0;
            end else if (doWrite) wHeld <= 1'h0;
            else if (!wHeld) wready <= 1'h1;
        end
    end

    // write response follows both halves
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid <= 1'h0;
            bresp  <= `RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'h1;
            bresp  <= (bus.wrHit && strbOk) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) bvalid <= 1'h0;
    end

    // read channel: one read in flight
    always_ff @(posedge clk) begin
        if (rst) begin
            arready   <= 1'h0;
            arPending <= 1'h0;
            rvalid    <= 1'h0;
            rdata     <= 32'h00000000;
            rresp     <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arAddrQ   <= araddr;
            arready   <= 1'h0;
            arPending <= 1'h1;
        end else if (arPending) begin
            arPending <= 1'h0;
            rvalid    <= 1'h1;
            rdata     <= bus.rdHit ? bus.rdData : 32'h00000000;
            rresp     <= bus.rdHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid) begin
            if (rready) rvalid <= 1'h0;
        end else arready <= 1'h1;
    end
endmodule // axil_slave

`default_nettype wire

// [core/op_decode.sv]
/*
 * Opcode decoder: maps the first instruction word to an operation,
 * its bit-select immediate and its cycle count.
 * Assumes a stable word while the core executes it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.svh"

module op_decode (
    input  wire logic [9:0] word1,
    output rss_pkg::op_type op,
    output logic [1:0]      bitSel,
    output logic            twoCycle
);
    import rss_pkg::*;

    logic isSubRet;
    logic isRetSkip;
    logic isIntRet;
    logic isClrHref;
    logic isSetBit;
    logic isSetCarry;
    logic isSetPort;
    logic isCmpImm;

    // exact matches, except the bit set which carries j in its low bits
    assign isSubRet   = word1 == `OPC_SUB_RET;
    assign isRetSkip  = word1 == `OPC_RET_SKIP;
    assign isIntRet   = word1 == `OPC_INT_RET;
    assign isClrHref  = word1 == `OPC_CLR_HREF;
    assign isSetBit   = word1[9:2] == `OPC_SETBIT_HI; // RL12
    assign isSetCarry = word1 == `OPC_SET_CARRY;
    assign isSetPort  = word1 == `OPC_SET_PORT;
    assign isCmpImm   = word1 == `OPC_CMP_IMM;

    assign bitSel   = word1[1:0]; // RL12
    assign twoCycle = isSubRet || isRetSkip || isCmpImm;
    assign op = isSubRet   ? OP_SUB_RETURN :
                isIntRet   ? OP_INT_RETURN :
                isRetSkip  ? OP_RETURN_SKIP :
                isClrHref  ? OP_CLEAR_HIGH_REF :
                isSetBit   ? OP_SET_MEM_BIT :
                isSetCarry ? OP_SET_CARRY :
                isSetPort  ? OP_SET_PORT_D_BIT :
                isCmpImm   ? OP_COMPARE_IMM_SKIP : OP_NONE;
endmodule // op_decode

`default_nettype wire

// [verification/tb_return_set_skip_instr_group.sv]
/*
 * Self-checking bench of the return/set/skip execute block.
 * Assumes the core's AXI4-Lite register map and its issue latencies.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.svh"

// one compare: count it and report a mismatch at once
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb_return_set_skip_instr_group;
    import rss_pkg::*;
    logic              clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid;
    logic              highRefEnableFlag;
    logic [7:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata, v1, v2;
    logic [3:0]        wstrb, portD, a;
    logic [1:0]        bresp, rresp;
    logic [33:0]       note;
    logic [33:0]       expQ[$];
    int                failures, testsRun;

    return_set_skip_instr_group i_dut (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .portD(portD), .highRefEnableFlag(highRefEnableFlag));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // a hung handshake counts as a mismatch and closes the run
    task automatic hang_check(input logic answered);
        if (!answered) begin
            failures++;
            complete_run();
        end
    endtask

    // aw and w offered together, each dropped once taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 99);
        // bready stays up between writes, so a back-to-back call never
        // drives it twice in one step
        hang_check(bvalid);
        `CHK(bresp, (ad > `REG_MEM) ? `RESP_SLVERR : `RESP_OKAY)
    endtask

    // the expectation is noted first; the monitor judges the data
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        int n;
        n = 0;
        expQ.push_back({(ad > `REG_MEM) ? `RESP_SLVERR : `RESP_OKAY, e});
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 99);
        hang_check(rvalid);
    endtask

    // writes while busy are dropped, so let the instruction finish
    task automatic ex(input logic [31:0] w);
        wr(`REG_EXEC, w);
        repeat (3) @(posedge clk);
    endtask

    // oldest note against each read answer as it is handed over
    always @(posedge clk) begin
        if (rvalid && rready) begin
            note = expQ.pop_front();
            `CHK({rresp, rdata}, note)
        end
    end

    initial begin
        failures = 0;
        testsRun = 0;
        rst <= 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr, wdata} <= 48'h0;
        wstrb <= `STRB_FULL;
        v1 = $urandom(13361);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`REG_STATUS, 32'h0000_7000);
        `CHK({portD, highRefEnableFlag}, 5'h00)
        // two nested calls, then return-and-skip and a skipped word
        wr(`REG_CTRL, 32'h0123_0001);
        wr(`REG_CTRL, 32'h0456_0001);
        rd(`REG_STATUS, 32'h0000_1456);
        ex(`OPC_RET_SKIP);
        rd(`REG_CORE, 32'h0040_0000);
        rd(`REG_STATUS, 32'h0000_0123);
        ex(`OPC_SET_CARRY);
        rd(`REG_STATUS, 32'h0000_0124);
        rd(`REG_CORE, 32'h0000_0000);
        ex(`OPC_SUB_RET);
        rd(`REG_STATUS, 32'h0000_7000);
        // context saved at interrupt entry comes back on return
        // bits 19:18 read back as zero and skip stays clear
        v1 = $urandom & 32'h0033_FFFF;
        wr(`REG_CORE, v1);
        wr(`REG_CTRL, 32'h0300_0002);
        v2 = $urandom & 32'h0033_FFFF;
        wr(`REG_CORE, v2);
        ex(`OPC_INT_RET);
        rd(`REG_CORE, v1);
        rd(`REG_STATUS, 32'h0000_7000);
        // flag clear must leave carry alone
        wr(`REG_STATUS, 32'h0002_0000);
        `CHK(highRefEnableFlag, 1'b1)
        wr(`REG_CORE, 32'h0010_0000);
        ex(`OPC_CLR_HREF);
        `CHK(highRefEnableFlag, 1'b0)
        rd(`REG_CORE, 32'h0010_0000);
        v1 = $urandom & 32'h0003_FFFF;
        wr(`REG_CORE, v1);
        ex(`OPC_SET_CARRY);
        rd(`REG_CORE, v1 | 32'h0010_0000);
        // every bit select, bits gather in one nibble
        wr(`REG_CORE, 32'h0000_9000);
        wr(`REG_MEM, 32'h0);
        for (int j = 0; j < 4; j++) begin
            ex(32'h05C + 32'(j));
            rd(`REG_MEM, (32'h2 << j) - 32'h1);
        end
        wr(`REG_STATUS, 32'h0);
        for (int y = 0; y < 4; y++) begin
            wr(`REG_CORE, 32'(y) << 12);
            ex(`OPC_SET_PORT);
            `CHK(portD, 4'((5'h02 << y) - 5'h01))
        end
        // every immediate; even passes match, odd ones are random
        for (int i = 0; i < 16; i++) begin
            a = (i % 2 == 1) ? 4'($urandom) : 4'(i);
            wr(`REG_CORE, {28'h0, a});
            ex((32'(i) << 16) | 32'(`OPC_CMP_IMM));
            rd(`REG_CORE, {9'h0, a == 4'(i), 18'h0, a});
        end
        wr(8'h20, $urandom);
        rd(8'h20, 32'h0);
        complete_run();
    end
endmodule // tb_return_set_skip_instr_group

`default_nettype wire
